// File: logic/ppcfg_pkg.sv
// Package of offsets, fields, resets and encodings for the port config bank
package ppcfg_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte addresses
  localparam logic [11:0] ADDR_PORT_MODE  = 12'h3c0;
  localparam logic [11:0] ADDR_DRIVE_STR  = 12'h3c4;
  localparam logic [11:0] ADDR_STATUS     = 12'h3c8;
  // Printed indices, kept for reference
  localparam logic [7:0]  IDX_PORT_MODE   = 8'hf0;
  localparam logic [7:0]  IDX_DRIVE_STR   = 8'hf1;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [7:0]  RST_PORT_MODE   = 8'h3c;
  localparam logic [7:0]  RST_DRIVE_STR   = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int          MODE_LSB        = 0;
  localparam int          THR_LSB         = 3;
  localparam int          ITYPE_BIT       = 7;
  localparam int          STEER_LSB       = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Port mode encodings
  typedef enum logic [2:0] {
    PPCFG_SPP       = 3'h0,
    PPCFG_EPP19     = 3'h1,
    PPCFG_ECP       = 3'h2,
    PPCFG_ECP_EPP19 = 3'h3,
    PPCFG_PRINTER   = 3'h4,
    PPCFG_EPP17     = 3'h5,
    PPCFG_RSVD6     = 3'h6,
    PPCFG_ECP_EPP17 = 3'h7
  } ppcfg_mode_t;

  // Drive steering encodings
  localparam logic [1:0]  STEER_NORMAL    = 2'h0;
  localparam logic [1:0]  STEER_SECOND    = 2'h1;
  localparam logic [1:0]  STEER_BOTH      = 2'h2;

endpackage

// File: logic/ppcfg_mode_decode.sv
// Decoder of port mode field into protocol enables
`timescale 1ns/1ps
module ppcfg_mode_decode (
  input  wire logic [2:0] mode,
  output logic            printer_en,
  output logic            spp_en,
  output logic            epp_en,
  output logic            epp17_sel,
  output logic            ecp_en
);

  always_comb begin
    printer_en = 1'b0;
    spp_en     = 1'b0;
    epp_en     = 1'b0;
    epp17_sel  = 1'b0;
    ecp_en     = 1'b0;
    case (mode)
      ppcfg_pkg::PPCFG_PRINTER: begin
        printer_en = 1'b1;
      end
      ppcfg_pkg::PPCFG_SPP: begin
        spp_en = 1'b1;
      end
      ppcfg_pkg::PPCFG_EPP19: begin
        spp_en = 1'b1;
        epp_en = 1'b1;
      end
      ppcfg_pkg::PPCFG_EPP17: begin
        spp_en    = 1'b1;
        epp_en    = 1'b1;
        epp17_sel = 1'b1;
      end
      ppcfg_pkg::PPCFG_ECP: begin
        ecp_en = 1'b1;
      end
      ppcfg_pkg::PPCFG_ECP_EPP19: begin
        ecp_en = 1'b1;
        epp_en = 1'b1;
      end
      ppcfg_pkg::PPCFG_ECP_EPP17: begin
        ecp_en    = 1'b1;
        epp_en    = 1'b1;
        epp17_sel = 1'b1;
      end
      default: begin
        // Undefined code: fall back to printer behaviour
        printer_en = 1'b1;
      end
    endcase
  end

endmodule

// File: logic/ppcfg_irq_gen.sv
// Parallel port interrupt shaping: pulsed low or level tracking
`timescale 1ns/1ps
module ppcfg_irq_gen (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic irq_type,
  input  wire logic printer_en,
  input  wire logic spp_en,
  input  wire logic epp_en,
  input  wire logic ecp_en,
  input  wire logic ecp_fifo_mode,
  input  wire logic printer_acknowledge_n,
  input  wire logic ecp_irq_event,
  output logic      irq_out,
  output logic      irq_oe
);

  logic ack_d_ff;
  logic nxt_ack_d;
  logic nxt_pulse;
  logic out_ff;
  logic nxt_out;
  logic oe_ff;
  logic nxt_oe;
  logic type_valid;

  always_comb begin
    // Type bit ignored in printer and plain bidirectional modes
    type_valid = !(printer_en || (spp_en && !epp_en));
    nxt_ack_d  = printer_acknowledge_n;
    nxt_pulse  = 1'b0;
    nxt_out    = printer_acknowledge_n;
    nxt_oe     = 1'b1;
    if (ecp_en && ecp_fifo_mode) begin
      nxt_out = ecp_irq_event;
      nxt_oe  = 1'b1;
    end else if (type_valid && irq_type) begin
      // One-cycle low pulse on falling ack edge, then high-Z
      nxt_pulse = ack_d_ff && !printer_acknowledge_n;
      nxt_out   = 1'b0;
      nxt_oe    = nxt_pulse;
    end else if (type_valid) begin
      nxt_out = printer_acknowledge_n;
      nxt_oe  = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_d_ff <= 1'b1;
      out_ff   <= 1'b0;
      oe_ff    <= 1'b0;
    end else begin
      ack_d_ff <= nxt_ack_d;
      out_ff   <= nxt_out;
      oe_ff    <= nxt_oe;
    end
  end

  assign irq_out = out_ff;
  assign irq_oe  = oe_ff;

endmodule

// File: logic/ppcfg_regs.sv
// APB register bank for parallel port mode and floppy pin steering
`timescale 1ns/1ps
module ppcfg_regs (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        printer_acknowledge_n,
  input  wire logic        ecp_fifo_mode,
  input  wire logic        ecp_irq_event,
  output logic             irq_out,
  output logic             irq_oe,
  output logic      [2:0]  port_mode,
  output logic      [3:0]  fifo_threshold,
  output logic             printer_en,
  output logic             spp_en,
  output logic             epp_en,
  output logic             epp17_sel,
  output logic             ecp_en,
  output logic             floppy0_on_pport,
  output logic             floppy1_on_pport,
  output logic      [1:0]  floppy_pin_steering
);

  ////////////////////////////////////////////////////////////////////////////
  // Register state
  logic [7:0]  mode_ff;
  logic [7:0]  nxt_mode;
  logic [7:0]  steer_ff;
  logic [7:0]  nxt_steer;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic        err_ff;
  logic        nxt_err;
  logic        f0_ff;
  logic        nxt_f0;
  logic        f1_ff;
  logic        nxt_f1;
  logic        setup;
  logic        hit_mode;
  logic        hit_steer;
  logic        hit_stat;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode; zero wait states, answer in the access phase
  always_comb begin
    setup     = psel && !penable;
    hit_mode  = paddr == ppcfg_pkg::ADDR_PORT_MODE;
    hit_steer = paddr == ppcfg_pkg::ADDR_DRIVE_STR;
    hit_stat  = paddr == ppcfg_pkg::ADDR_STATUS;
    nxt_mode  = mode_ff;
    nxt_steer = steer_ff;
    nxt_rdata = rdata_ff;
    nxt_err   = err_ff;
    if (setup) begin
      nxt_err   = !(hit_mode || hit_steer || (hit_stat && !pwrite));
      nxt_rdata = 32'h0000_0000;
      if (!pwrite) begin
        if (hit_mode) begin
          nxt_rdata = {24'h00_0000, mode_ff};
        end else if (hit_steer) begin
          nxt_rdata = {24'h00_0000, steer_ff};
        end else if (hit_stat) begin
          nxt_rdata = {24'h00_0000, 1'b0, irq_oe, irq_out,
                       floppy1_on_pport, floppy0_on_pport,
                       ecp_en, epp_en, spp_en};
        end
      end
    end
    if (psel && penable && pwrite && pstrb[0]) begin
      if (hit_mode) begin
        nxt_mode = pwdata[7:0];
      end else if (hit_steer) begin
        // Reserved bits stored as written; software keeps them zero
        nxt_steer = pwdata[7:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_ff  <= ppcfg_pkg::RST_PORT_MODE;
      steer_ff <= ppcfg_pkg::RST_DRIVE_STR;
      rdata_ff <= 32'h0000_0000;
      err_ff   <= 1'b0;
    end else begin
      mode_ff  <= nxt_mode;
      steer_ff <= nxt_steer;
      rdata_ff <= nxt_rdata;
      err_ff   <= nxt_err;
    end
  end

  assign pready  = 1'b1;
  assign prdata  = (psel && penable) ? rdata_ff : 32'h0000_0000;
  assign pslverr = psel && penable && err_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Floppy pin steering, registered to keep pin muxes glitch free
  always_comb begin
    case (steer_ff[ppcfg_pkg::STEER_LSB +: 2])
      ppcfg_pkg::STEER_NORMAL: begin
        nxt_f0 = 1'b0;
        nxt_f1 = 1'b0;
      end
      ppcfg_pkg::STEER_SECOND: begin
        nxt_f0 = 1'b0;
        nxt_f1 = 1'b1;
      end
      ppcfg_pkg::STEER_BOTH: begin
        nxt_f0 = 1'b1;
        nxt_f1 = 1'b1;
      end
      default: begin
        nxt_f0 = 1'b0;
        nxt_f1 = 1'b0;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      f0_ff <= 1'b0;
      f1_ff <= 1'b0;
    end else begin
      f0_ff <= nxt_f0;
      f1_ff <= nxt_f1;
    end
  end

  assign floppy0_on_pport    = f0_ff;
  assign floppy1_on_pport    = f1_ff;
  assign floppy_pin_steering = steer_ff[ppcfg_pkg::STEER_LSB +: 2];
  assign port_mode           = mode_ff[ppcfg_pkg::MODE_LSB +: 3];
  assign fifo_threshold      = mode_ff[ppcfg_pkg::THR_LSB +: 4];

  ////////////////////////////////////////////////////////////////////////////
  // Submodules
  ppcfg_mode_decode u_dec (
    .mode       (mode_ff[ppcfg_pkg::MODE_LSB +: 3]),
    .printer_en (printer_en),
    .spp_en     (spp_en),
    .epp_en     (epp_en),
    .epp17_sel  (epp17_sel),
    .ecp_en     (ecp_en)
  );

  ppcfg_irq_gen u_irq (
    .pclk                  (pclk),
    .presetn               (presetn),
    .irq_type              (mode_ff[ppcfg_pkg::ITYPE_BIT]),
    .printer_en            (printer_en),
    .spp_en                (spp_en),
    .epp_en                (epp_en),
    .ecp_en                (ecp_en),
    .ecp_fifo_mode         (ecp_fifo_mode),
    .printer_acknowledge_n (printer_acknowledge_n),
    .ecp_irq_event         (ecp_irq_event),
    .irq_out               (irq_out),
    .irq_oe                (irq_oe)
  );

endmodule

// File: dv/ppcfg_printer_model.sv
// Printer side model answering with acknowledge pulses
`timescale 1ns/1ps
module ppcfg_printer_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       ack_go,
  input  wire logic [3:0] ack_len,
  output logic            printer_acknowledge_n
);
  logic [3:0] cnt_ff;
  ////////////////////////////////////////////////////////////////////////////
  // Line idles high on its pull-up; length sets how many cycles acknowledge stays low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff <= 4'h0;
      printer_acknowledge_n <= 1'b1;
    end else if (ack_go) begin
      cnt_ff <= ack_len;
      printer_acknowledge_n <= 1'b0;
    end else if (cnt_ff != 4'h0) begin
      cnt_ff <= cnt_ff - 4'h1;
      printer_acknowledge_n <= (cnt_ff == 4'h1);
    end
  end
endmodule

// File: dv/ppcfg_monitor.sv
// Checker of decode, steering and interrupt pin behaviour
`timescale 1ns/1ps
module ppcfg_monitor (
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic [2:0] port_mode,
  input wire logic       printer_en,
  input wire logic       epp_en,
  input wire logic       epp17_sel,
  input wire logic       ecp_en,
  input wire logic [1:0] floppy_pin_steering,
  input wire logic       floppy0_on_pport,
  input wire logic       floppy1_on_pport,
  input wire logic       printer_acknowledge_n,
  input wire logic       ecp_fifo_mode,
  input wire logic       ecp_irq_event,
  input wire logic       irq_out,
  input wire logic       irq_oe
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////////////////////
  a_mode_plain: assert property (
    port_mode inside {3'h0, 3'h4} |-> printer_en == port_mode[2]
      && !epp_en && !ecp_en) else $error("plain mode decode wrong");
  a_mode_epp: assert property (
    port_mode inside {3'h1, 3'h5} |-> epp_en && !ecp_en && !printer_en
      && epp17_sel == port_mode[2]) else $error("epp decode wrong");
  a_mode_ecp: assert property (
    port_mode inside {3'h2, 3'h3, 3'h7} |-> ecp_en
      && epp_en == port_mode[0]
      && (!port_mode[0] || epp17_sel == port_mode[2]))
    else $error("ecp decode wrong");
  a_steer_second: assert property (
    (floppy_pin_steering == 2'h1) [*2] |-> floppy1_on_pport
      && !floppy0_on_pport) else $error("second drive steering wrong");
  a_steer_both: assert property (
    (floppy_pin_steering == 2'h2) [*2] |-> floppy1_on_pport
      && floppy0_on_pport) else $error("both drive steering wrong");
  a_steer_normal: assert property (
    (floppy_pin_steering inside {2'h0, 2'h3}) [*2] |-> !floppy1_on_pport
      && !floppy0_on_pport) else $error("normal steering wrong");
  // Fifo phase takes priority, so it is kept out of this one
  // Release edge skipped: flops still hold reset values there
  a_type_ignored: assert property (
    presetn && port_mode inside {3'h0, 3'h4} && !ecp_fifo_mode |=> irq_oe
      && irq_out == $past(printer_acknowledge_n))
    else $error("pin does not follow acknowledge");
  a_ecp_level: assert property (
    presetn && ecp_fifo_mode && ecp_en |=> irq_oe
      && irq_out == $past(ecp_irq_event)) else $error("level irq wrong");
endmodule
bind ppcfg_regs ppcfg_monitor ppcfg_monitor_i (
  .pclk(pclk), .presetn(presetn), .port_mode(port_mode),
  .printer_en(printer_en), .epp_en(epp_en), .epp17_sel(epp17_sel),
  .ecp_en(ecp_en), .floppy_pin_steering(floppy_pin_steering),
  .floppy0_on_pport(floppy0_on_pport),
  .floppy1_on_pport(floppy1_on_pport),
  .printer_acknowledge_n(printer_acknowledge_n),
  .ecp_fifo_mode(ecp_fifo_mode), .ecp_irq_event(ecp_irq_event),
  .irq_out(irq_out), .irq_oe(irq_oe));

// File: dv/tb_top.sv
// Self-checking bench for the port config register bank
`timescale 1ns/1ps
module tb_top;
  localparam logic [11:0] AM = ppcfg_pkg::ADDR_PORT_MODE;
  localparam logic [11:0] AD = ppcfg_pkg::ADDR_DRIVE_STR;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        ack_go, fmd, evt, ack_n, oe, iq, er, prn, spp, epp;
  logic        e17, ecp, fd0, fd1;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb, thr, alen;
  logic [2:0]  pm;
  logic [1:0]  st;
  int          errors, checks_done;
  ppcfg_regs ppcfg_regs_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .printer_acknowledge_n(ack_n), .ecp_fifo_mode(fmd),
    .ecp_irq_event(evt), .irq_out(iq), .irq_oe(oe), .port_mode(pm),
    .fifo_threshold(thr), .printer_en(prn), .spp_en(spp), .epp_en(epp),
    .epp17_sel(e17), .ecp_en(ecp), .floppy0_on_pport(fd0),
    .floppy1_on_pport(fd1), .floppy_pin_steering(st));
  ppcfg_printer_model ppcfg_printer_model_i (.pclk(pclk),
    .presetn(presetn), .ack_go(ack_go), .ack_len(alen),
    .printer_acknowledge_n(ack_n));
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      errors++;
      $display("unexpected %0t got %h want %h", $time, s, e);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic t_reset();
    apb(1'b0, AM, '0);
    chk(rd, 32'h3c);
    chk({prn, thr}, 5'h17);
    apb(1'b0, AD, '0);
    chk(rd, 32'h0);
  endtask
  task automatic t_modes();
    logic [2:0] m;
    for (int i = 0; i < 8; i++) begin
      m = 3'(i);
      if (m == 3'h6) continue;
      apb(1'b1, AM, {25'h0, 4'h7, m});
      #1;
      chk({prn, epp, ecp}, {m == 3'h4, m[0], m[1]});
      if (m[0]) chk(e17, m[2]);
      if (!m[1]) chk(spp, m != 3'h4);
      chk(pm, m);
    end
    apb(1'b1, AM, 32'h3e);
    #1;
    chk({prn, spp, epp, ecp}, 4'h8);
    apb(1'b1, AM, 32'h7c);
    #1;
    chk(thr, 4'hf);
  endtask
  // Ack held three cycles, so a pulse and a follower part ways
  task automatic irq_run(input logic [7:0] mv, input logic fol);
    apb(1'b1, AM, {24'h0, mv});
    @(posedge pclk);
    alen <= 4'h3;
    ack_go <= 1'b1;
    @(posedge pclk);
    ack_go <= 1'b0;
    @(posedge pclk);
    #1;
    chk({oe, iq}, 2'b10);
    @(posedge pclk);
    #1;
    chk(oe, fol);
    repeat (3) @(posedge pclk);
    #1;
    chk(oe, fol);
    if (fol) chk(iq, 1'b1);
  endtask
  task automatic t_ecp();
    apb(1'b1, AM, 32'h82);
    fmd <= 1'b1;
    evt <= 1'b1;
    repeat (3) @(posedge pclk);
    #1;
    chk({oe, iq}, 2'b11);
    @(posedge pclk);
    evt <= 1'b0;
    repeat (2) @(posedge pclk);
    #1;
    chk({oe, iq}, 2'b10);
    @(posedge pclk);
    fmd <= 1'b0;
  endtask
  task automatic t_steer();
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, AD, {30'h0, 2'(i)});
      repeat (2) @(posedge pclk);
      #1;
      chk({st, fd1, fd0},
          {2'(i), i == 1 || i == 2, i == 2});
    end
  endtask
  task automatic t_err();
    apb(1'b0, 12'h3d0, '0);
    chk({er, rd[0]}, 2'b10);
    apb(1'b1, ppcfg_pkg::ADDR_STATUS, 32'h0);
    chk(er, 1'b1);
    pstrb <= 4'h0;
    apb(1'b1, AM, 32'hff);
    pstrb <= 4'hf;
    apb(1'b0, AM, '0);
    chk(rd, 32'h82);
    apb(1'b0, ppcfg_pkg::ADDR_STATUS, '0);
    chk(rd, 32'h4);
    chk(er, 1'b0);
    apb(1'b1, AD, 32'h2);
    @(posedge pclk);
    #1;
    chk({fd0, fd1}, 2'b11);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    #1;
    chk({fd0, fd1}, 2'b00);
    @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
  endtask
  task automatic close_out();
    $display("errors %0d checks %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge pclk);
    errors++;
    close_out();
  end
  initial begin
    {presetn, psel, penable, pwrite, ack_go, fmd, evt} = '0;
    {paddr, pwdata, alen} = '0;
    pstrb = 4'hf;
    errors = 0;
    checks_done = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_modes();
    irq_run(8'h81, 1'b0);
    irq_run(8'hbd, 1'b0);
    irq_run(8'h01, 1'b1);
    irq_run(8'h03, 1'b1);
    irq_run(8'h84, 1'b1);
    irq_run(8'h80, 1'b1);
    t_ecp();
    t_steer();
    t_err();
    close_out();
  end
endmodule
